// ---- src/bpsc_dev.sv ----
/*
  bridge end: power state machine, config registers, bus gating,
  soft reset from D3hot and aux-powered wake context.
  assumes: i_rst_b is the primary bus reset; i_aux_rst_b is the
  aux-supply power-on reset; pins arrive asynchronously.
*/
// Summary of operation
// [R01] supports D0, D1, D2, D3hot and D3cold
// [R02] D3hot leaves by D0 write or reset
// [R03] D3cold leaves only via reset with power
// [R04] reset gives D0 uninit, wake context kept while wen set
// [R05] D0 entry uninitialized until software initializes
// [R06] D2 initiates only wake event signalling
// [R07] D2 answers config, memory/io disabled
// [R08] no mastering or interrupts until active
// [R09] software waits 200 us after D2 exit
// [R10] D3 keeps wake context when enabled
// [R11] D3 exits only to D0, full reinit
// [R12] software waits 10 ms after D3 exit
// [R13] D3hot config readable, wake bits operational
// [R14] D3hot still answers configuration accesses
// [R15] D3hot to D0 soft reset, no reset lines
// [R16] drivers disabled during soft reset transition
// [R17] only wake context survives soft reset
// [R18] loss of supply enters D3cold at once
// [R19] reset from D3 reloads power-on defaults
// [R20] aux keeps socket mask/events and caps bit15
// [R21] D3cold with aux: card removal cuts slot power
// [R22] D2 stops secondary card clock
// [R23] software sets/reads state via power field
// [R24] two-bit state field, illegal writes ignored
`timescale 1ns/1ps
`include "bpsc_regs.svh"
module bpsc_dev
  import bpsc_pkg::*;
#(
  parameter logic [15:0] CAPS_VAL = `BPSC_CAPS_RST
) (
  // clock and resets
  input  wire logic i_ref_clk,
  input  wire logic i_rst_b,
  input  wire logic i_aux_rst_b,
  // config link
  bpsc_if.dev       cfg,
  // pins from board and slot
  input  wire logic i_vcc_good,
  input  wire logic i_aux_pwr,
  input  wire logic i_card_present,
  input  wire logic i_card_wake,
  // gating and slot controls
  output logic       o_mem_io_en,
  output logic       o_master_en,
  output logic       o_irq_en,
  output logic       o_drivers_en,
  output logic       o_card_clk_run,
  output logic       o_card_bus_reset_n,
  output logic       o_slot_vcc_en,
  output logic       o_wake_req,
  output logic [1:0] o_power_state
);
  localparam int SRW = $clog2(`BPSC_SOFT_RST_CYC + 1);
  if (CAPS_VAL[15] != 1'b1) begin : g_caps_check
    $error("bridge must claim wake from D3cold");
  end

  function automatic logic [1:0] ps_of(input bpsc_state_t s);
    unique case (s)
      ST_D1:                            ps_of = BPSC_PS_D1;
      ST_D2:                            ps_of = BPSC_PS_D2;
      ST_D3HOT, ST_SOFT_RST, ST_D3COLD: ps_of = BPSC_PS_D3HOT;
      ST_D0_UNINIT, ST_D0_ACT:          ps_of = BPSC_PS_D0;
    endcase
  endfunction : ps_of

  // ----------------------------------------
  // pin synchronisers (aux domain, alive in D3cold)
  // ----------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  always_ff @(posedge i_ref_clk or negedge i_aux_rst_b) begin
    if (!i_aux_rst_b) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {i_card_wake, i_card_present, i_aux_pwr, i_vcc_good};
      sync_b <= sync_a;
    end
  end
  wire vcc_ok   = sync_b[0];
  wire aux_ok   = sync_b[1];
  wire card_in  = sync_b[2];
  wire card_wk  = sync_b[3];

  // ----------------------------------------
  // main state, command and readback
  // ----------------------------------------
  bpsc_state_t state, next_state;
  logic [3:0]  cmd, next_cmd;
  logic [SRW-1:0] srcnt, next_srcnt;
  logic [15:0] rdata, next_rdata;
  logic        rvalid, next_rvalid;
  logic        rst_seen, next_rst_seen;
  logic        next_mem_io;
  logic        next_mst;
  logic        next_irq;
  logic        next_drv;
  logic        next_clk;
  logic        next_card_bus_reset_n;
  logic [1:0]  next_ps;
  // wake context (aux domain)
  logic        wen, next_wen;
  logic        wflag, next_wflag;
  logic [7:0]  smask, next_smask;
  logic [7:0]  sevt, next_sevt;
  logic        slot, next_slot;
  logic        card_prev, wk_prev;
  logic        next_wake;

  wire pwr_up  = state != ST_D3COLD;
  wire acc_ok  = pwr_up && state != ST_SOFT_RST;  // drivers off while soft resetting
  wire wr_ps   = acc_ok && cfg.cfg_wr && cfg.cfg_addr == `BPSC_REG_POWER_CONTROL_STATUS_REG;
  wire wr_cmd  = acc_ok && cfg.cfg_wr && cfg.cfg_addr == `BPSC_REG_CMD;
  wire wr_sock = acc_ok && cfg.cfg_wr && cfg.cfg_addr == `BPSC_REG_SOCK;
  wire [1:0] wps = cfg.cfg_wdata[`BPSC_PS_LSB +: 2];
  wire removed = card_prev && !card_in;
  wire [7:0] new_evt = {6'h00, removed, card_wk && !wk_prev};

  always_comb begin
    next_state    = state;
    next_cmd      = cmd;
    next_srcnt    = srcnt;
    next_rdata    = rdata;
    next_rvalid   = 1'b0;
    next_rst_seen = 1'b0;
    if (!vcc_ok) begin
      next_state = ST_D3COLD;                             // [R18]
      next_cmd   = `BPSC_CMD_RST;
    end else begin
      unique case (state)
        ST_D0_UNINIT, ST_D0_ACT, ST_D1, ST_D2: begin
          if (wr_ps) begin                                // [R23]
            unique case (wps)                             // [R24]
              BPSC_PS_D0: next_state = (state == ST_D0_UNINIT) ? ST_D0_UNINIT : ST_D0_ACT;
              BPSC_PS_D1: next_state = (state == ST_D0_UNINIT) ? state : ST_D1;
              BPSC_PS_D2: next_state = (state == ST_D0_UNINIT) ? state : ST_D2;
              BPSC_PS_D3HOT: next_state = ST_D3HOT;       // [R01]
            endcase
          end else if (wr_cmd && state == ST_D0_UNINIT && cfg.cfg_wdata[3:0] != 4'h0) begin
            next_state = ST_D0_ACT;                       // [R05]
          end
          if (wr_cmd) next_cmd = cfg.cfg_wdata[3:0];
        end
        ST_D3HOT: begin
          if (wr_ps && wps == BPSC_PS_D0) begin           // [R02] [R11]
            next_state = ST_SOFT_RST;                     // [R15]
            next_srcnt = SRW'(`BPSC_SOFT_RST_CYC);
            next_cmd   = `BPSC_CMD_RST;                   // [R17]
          end
        end
        ST_SOFT_RST: begin
          next_srcnt = srcnt - SRW'(1);
          if (srcnt == SRW'(1)) next_state = ST_D0_UNINIT;  // [R05]
        end
        ST_D3COLD: next_state = ST_D3COLD;                // [R03]
      endcase
    end
    if (acc_ok && cfg.cfg_rd) begin                       // [R07] [R13] [R14]
      next_rvalid = 1'b1;
      unique case (cfg.cfg_addr)
        `BPSC_REG_POWER_CONTROL_STATUS_REG: next_rdata = {wflag, 6'h00, wen, 6'h00, ps_of(state)};
        `BPSC_REG_CMD:   next_rdata = {11'h000, slot, cmd};
        `BPSC_REG_CAPS:  next_rdata = CAPS_VAL;           // [R20]
        `BPSC_REG_SOCK:  next_rdata = {sevt, smask};
      endcase
    end
    next_ps     = ps_of(next_state);
    // memory/io, mastering and interrupts only once active
    next_mem_io = next_state == ST_D0_ACT && next_cmd[1:0] != 2'h0;   // [R07]
    next_mst    = next_state == ST_D0_ACT && next_cmd[`BPSC_CMD_MST];  // [R06] [R08]
    next_irq    = next_state == ST_D0_ACT && next_cmd[`BPSC_CMD_IRQ];  // [R08]
    next_drv    = next_state != ST_SOFT_RST && next_state != ST_D3COLD; // [R16]
    next_clk    = next_state == ST_D0_UNINIT || next_state == ST_D0_ACT
                  || next_state == ST_D1;                 // [R22]
    next_card_bus_reset_n   = next_state != ST_D3COLD;                // [R15]
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin                                   // [R04] [R19]
      state              <= ST_D0_UNINIT;
      cmd                <= `BPSC_CMD_RST;
      srcnt              <= '0;
      rdata              <= 16'h0000;
      rvalid             <= 1'b0;
      rst_seen           <= 1'b1;
      o_mem_io_en        <= 1'b0;
      o_master_en        <= 1'b0;
      o_irq_en           <= 1'b0;
      o_drivers_en       <= 1'b0;
      o_card_clk_run     <= 1'b0;
      o_card_bus_reset_n <= 1'b0;
      o_power_state      <= BPSC_PS_D0;
    end else begin
      state              <= next_state;
      cmd                <= next_cmd;
      srcnt              <= next_srcnt;
      rdata              <= next_rdata;
      rvalid             <= next_rvalid;
      rst_seen           <= next_rst_seen;
      o_mem_io_en        <= next_mem_io;
      o_master_en        <= next_mst;
      o_irq_en           <= next_irq;
      o_drivers_en       <= next_drv;
      o_card_clk_run     <= next_clk;
      o_card_bus_reset_n <= next_card_bus_reset_n;
      o_power_state      <= next_ps;
    end
  end
  assign cfg.cfg_rdata  = rdata;
  assign cfg.cfg_rvalid = rvalid;

  // ----------------------------------------
  // wake context: survives soft reset, and primary reset only while wen is set
  // ----------------------------------------
  always_comb begin
    next_wen   = wen;
    next_wflag = wflag;
    next_smask = smask;
    next_sevt  = sevt;
    next_slot  = slot;
    if (rst_seen && !wen) begin                           // [R04] [R10]
      next_wflag = 1'b0;
      next_smask = `BPSC_MASK_RST;
      next_sevt  = 8'h00;
      next_slot  = 1'b0;
    end
    if (wr_ps) begin                                      // [R13]
      next_wen = cfg.cfg_wdata[`BPSC_WEN_BIT];
      if (cfg.cfg_wdata[`BPSC_WFLAG_BIT]) next_wflag = 1'b0;
    end
    if (wr_cmd) next_slot = cfg.cfg_wdata[`BPSC_CMD_SLOT];
    if (wr_sock) begin
      next_smask = cfg.cfg_wdata[7:0];
      next_sevt  = next_sevt & ~cfg.cfg_wdata[15:8];
    end
    // set beats clear so an event in the clearing cycle survives
    next_sevt = next_sevt | new_evt;                      // [R20]
    if ((new_evt & smask) != 8'h00) next_wflag = 1'b1;
    if (removed && (pwr_up || aux_ok)) next_slot = 1'b0;  // [R21]
    next_wake = next_wflag && next_wen;                   // [R06]
  end

  always_ff @(posedge i_ref_clk or negedge i_aux_rst_b) begin
    if (!i_aux_rst_b) begin
      wen           <= 1'b0;
      wflag         <= 1'b0;
      smask         <= `BPSC_MASK_RST;
      sevt          <= 8'h00;
      slot          <= 1'b0;
      card_prev     <= 1'b0;
      wk_prev       <= 1'b0;
      o_wake_req    <= 1'b0;
      o_slot_vcc_en <= 1'b0;
    end else begin
      wen           <= next_wen;
      wflag         <= next_wflag;
      smask         <= next_smask;
      sevt          <= next_sevt;
      slot          <= next_slot;
      card_prev     <= card_in;
      wk_prev       <= card_wk;
      o_wake_req    <= next_wake;
      o_slot_vcc_en <= next_slot && card_in;
    end
  end
endmodule : bpsc_dev

// ---- src/bpsc_regs.svh ----
/*
  register indices, field positions, reset values and timing figures
  for the bridge power state control block.
  assumes: included by bare name from bridge, host and bench modules.
*/
`ifndef BPSC_REGS_SVH
`define BPSC_REGS_SVH
// ----------------------------------------
// register indices (config word select)
// ----------------------------------------
`define BPSC_REG_POWER_CONTROL_STATUS_REG   2'h0
`define BPSC_REG_CMD     2'h1
`define BPSC_REG_CAPS    2'h2
`define BPSC_REG_SOCK    2'h3
// ----------------------------------------
// field positions
// ----------------------------------------
`define BPSC_PS_LSB      0
`define BPSC_WEN_BIT     8
`define BPSC_WFLAG_BIT   15
`define BPSC_CMD_MEM     0
`define BPSC_CMD_IO      1
`define BPSC_CMD_MST     2
`define BPSC_CMD_IRQ     3
`define BPSC_CMD_SLOT    4
`define BPSC_SOCK_EVT_LSB 8
`define BPSC_EVT_WAKE    0
`define BPSC_EVT_REMOVE  1
// ----------------------------------------
// reset values
// ----------------------------------------
`define BPSC_CAPS_RST    16'hf800
`define BPSC_CMD_RST     4'h0
`define BPSC_MASK_RST    8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define BPSC_CLK_MHZ     250
`define BPSC_D2_REC_US   200
`define BPSC_D3_REC_MS   10
`define BPSC_SOFT_RST_CYC 16
`endif

// ---- src/bpsc_pkg.sv ----
/*
  types shared by both ends of the power state control link.
  assumes: bpsc_regs.svh holds all numeric constants.
*/
package bpsc_pkg;
  typedef enum logic [1:0] {
    BPSC_PS_D0, BPSC_PS_D1, BPSC_PS_D2, BPSC_PS_D3HOT
  } bpsc_ps_t;
  typedef enum logic [2:0] {
    ST_D0_UNINIT, ST_D0_ACT, ST_D1, ST_D2, ST_D3HOT, ST_SOFT_RST, ST_D3COLD
  } bpsc_state_t;
  typedef enum logic [1:0] {
    H_IDLE, H_WAIT_RD, H_RECOVER
  } bpsc_hstate_t;
endpackage : bpsc_pkg

// ---- src/bpsc_if.sv ----
/*
  configuration access link between host software end and bridge.
  assumes: both ends share one clock; testbench instantiates it.
*/
`timescale 1ns/1ps
interface bpsc_if;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [1:0]  cfg_addr;
  logic [15:0] cfg_wdata;
  logic [15:0] cfg_rdata;
  logic        cfg_rvalid;
  modport dev  (input cfg_wr, cfg_rd, cfg_addr, cfg_wdata, output cfg_rdata, cfg_rvalid);
  modport host (output cfg_wr, cfg_rd, cfg_addr, cfg_wdata, input cfg_rdata, cfg_rvalid);
endinterface : bpsc_if

// ---- src/bpsc_host.sv ----
/*
  software end: issues config reads and writes, refuses non-D0
  state requests while in D3hot and holds off access during recovery times.
  assumes: device answers a read on the next cycle.
*/
`timescale 1ns/1ps
`include "bpsc_regs.svh"
module bpsc_host
  import bpsc_pkg::*;
#(
  parameter int D2_REC_CYC = `BPSC_D2_REC_US * `BPSC_CLK_MHZ,
  parameter int D3_REC_CYC = `BPSC_D3_REC_MS * 1000 * `BPSC_CLK_MHZ
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // request port
  input  wire logic        i_req,
  input  wire logic        i_wr,
  input  wire logic [1:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  // answer port
  output logic             o_ready,
  output logic             o_refused,
  output logic             o_rvalid,
  output logic [15:0]      o_rdata,
  // config link
  bpsc_if.host             cfg
);
  if (D2_REC_CYC < 1 || D3_REC_CYC < D2_REC_CYC) begin : g_rec_check
    $error("bad recovery counts");
  end

  bpsc_hstate_t st, next_st;
  logic [31:0] cnt, next_cnt;
  logic [1:0]  shadow, next_shadow;
  logic        wr_q, next_wr;
  logic        rd_q, next_rd;
  logic [1:0]  addr_q, next_addr;
  logic [15:0] wd_q, next_wd;
  logic        rdy_q, next_rdy;
  logic        ref_q, next_ref;
  logic        rv_q, next_rv;
  logic [15:0] rd_data, next_rd_data;

  wire take  = i_req && st == H_IDLE;
  wire is_ps = i_addr == `BPSC_REG_POWER_CONTROL_STATUS_REG;

  // ----------------------------------------
  // request sequencing
  // ----------------------------------------
  always_comb begin
    next_st      = st;
    next_cnt     = cnt;
    next_shadow  = shadow;
    next_wr      = 1'b0;
    next_rd      = 1'b0;
    next_addr    = addr_q;
    next_wd      = wd_q;
    next_ref     = 1'b0;
    next_rv      = 1'b0;
    next_rd_data = rd_data;
    unique case (st)
      H_IDLE: begin
        if (take) begin
          next_addr = i_addr;
          next_wd   = i_wdata;
          if (!i_wr) begin
            next_rd = 1'b1;
            next_st = H_WAIT_RD;
          end else if (is_ps && shadow == BPSC_PS_D3HOT && i_wdata[1:0] != BPSC_PS_D0) begin
            next_ref = 1'b1;                              // [R11]
          end else begin
            next_wr = 1'b1;
            if (is_ps) begin
              next_shadow = i_wdata[1:0];                 // [R23]
              if (i_wdata[1:0] == BPSC_PS_D0 && shadow == BPSC_PS_D2) begin
                next_cnt = 32'(D2_REC_CYC);               // [R09]
                next_st  = H_RECOVER;
              end else if (i_wdata[1:0] == BPSC_PS_D0 && shadow == BPSC_PS_D3HOT) begin
                next_cnt = 32'(D3_REC_CYC);               // [R12]
                next_st  = H_RECOVER;
              end
            end
          end
        end
      end
      H_WAIT_RD: begin
        if (cfg.cfg_rvalid) begin
          next_rv      = 1'b1;
          next_rd_data = cfg.cfg_rdata;
          next_st      = H_IDLE;
        end
      end
      H_RECOVER: begin
        next_cnt = cnt - 32'd1;
        if (cnt == 32'd1) next_st = H_IDLE;
      end
    endcase
    next_rdy = next_st == H_IDLE;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st        <= H_IDLE;
      cnt       <= 32'h0000_0000;
      shadow    <= BPSC_PS_D0;                            // [R02] [R03]
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      addr_q    <= 2'h0;
      wd_q      <= 16'h0000;
      rdy_q     <= 1'b0;
      ref_q     <= 1'b0;
      rv_q      <= 1'b0;
      rd_data   <= 16'h0000;
    end else begin
      st        <= next_st;
      cnt       <= next_cnt;
      shadow    <= next_shadow;
      wr_q      <= next_wr;
      rd_q      <= next_rd;
      addr_q    <= next_addr;
      wd_q      <= next_wd;
      rdy_q     <= next_rdy;
      ref_q     <= next_ref;
      rv_q      <= next_rv;
      rd_data   <= next_rd_data;
    end
  end
  assign cfg.cfg_wr    = wr_q;
  assign cfg.cfg_rd    = rd_q;
  assign cfg.cfg_addr  = addr_q;
  assign cfg.cfg_wdata = wd_q;
  assign o_ready       = rdy_q;
  assign o_refused     = ref_q;
  assign o_rvalid      = rv_q;
  assign o_rdata       = rd_data;
endmodule : bpsc_host

// ---- sim/bpsc_properties.sv ----
/*
  checker on the config link and the bridge gating outputs.
  assumes: instantiated by the bench top beside the link.
*/
`timescale 1ns/1ps
module bpsc_properties (
  // clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  // config link
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [1:0]  cfg_addr,
  input wire logic [15:0] cfg_wdata,
  input wire logic        cfg_rvalid,
  // bridge pins and gating
  input wire logic        i_vcc_good,
  input wire logic        i_card_present,
  input wire logic        o_mem_io_en,
  input wire logic        o_master_en,
  input wire logic        o_irq_en,
  input wire logic        o_drivers_en,
  input wire logic        o_card_clk_run,
  input wire logic        o_card_bus_reset_n,
  input wire logic        o_slot_vcc_en,
  input wire logic [1:0]  o_power_state
);
  // ----------------
  // assertions
  // ----------------
  wire logic in_d2 = o_power_state == 2'h2;
  // drivers_en term keeps a write during soft reset out of it
  wire logic d3_exit = cfg_wr && cfg_addr == 2'h0 && cfg_wdata[1:0] == 2'h0 && o_power_state == 2'h3
                       && o_drivers_en && i_vcc_good;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);
  chk_read_answer: assert property (cfg_rd && o_drivers_en && i_vcc_good |=> cfg_rvalid)
    else $error("config read not answered");
  chk_rvalid_cause: assert property (cfg_rvalid |-> $past(cfg_rd))
    else $error("read answer without read");
  chk_host_spacing: assert property ((cfg_wr || cfg_rd) |=> !(cfg_wr || cfg_rd))
    else $error("config requests back to back");
  chk_d2_quiet: assert property (in_d2 |-> !(o_mem_io_en || o_master_en || o_irq_en))
    else $error("bus activity enabled in d2");
  chk_d2_clock: assert property (in_d2 |-> !o_card_clk_run)
    else $error("card clock running in d2");
  chk_soft_reset: assert property (d3_exit |=> (!o_drivers_en && o_card_bus_reset_n) [*8])
    else $error("soft reset drove bus or reset");
  chk_reset_state: assert property ($rose(i_rst_b) |-> o_power_state == 2'h0 && !o_master_en)
    else $error("reset did not give d0");
  chk_cold_entry: assert property ($fell(i_vcc_good) |-> ##[1:5] (o_power_state == 2'h3 && !o_card_clk_run))
    else $error("supply loss did not give d3cold");
  chk_removal_cut: assert property ($fell(i_card_present) |-> ##[1:5] !o_slot_vcc_en)
    else $error("slot supply kept after removal");
  cov_read: cover property (cfg_rvalid);
  cov_d2: cover property (in_d2 && !o_card_clk_run);
  cov_soft: cover property ($fell(o_drivers_en));
  cov_cut: cover property ($fell(o_slot_vcc_en));
endmodule : bpsc_properties

// ---- sim/bpsc_tb.sv ----
/*
  bench: host end and bridge end joined by the link.
  assumes: recovery counts shortened through host parameters.
*/
`timescale 1ns/1ps
`include "bpsc_regs.svh"
module bpsc_tb;
  localparam int D2R = 20;
  localparam int D3R = 40;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        aux_rst_b = 1'b0;
  logic        vcc_good = 1'b1;
  logic        card_in = 1'b1;
  logic        card_wake = 1'b0;
  logic        req = 1'b0;
  logic        wr = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic        ready, refused, rvalid, mem_io, master, irq, drv, cclk, card_bus_reset_n_n, slot, wake;
  logic [15:0] rdata, rd;
  logic [1:0]  pstate;
  logic        rf;
  int          wn;
  int          bad_count = 0;
  int          n_compared = 0;
  always #2 clk = ~clk;
  bpsc_if link ();
  bpsc_dev u_bpsc_dev (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_aux_rst_b(aux_rst_b), .cfg(link.dev), .i_vcc_good(vcc_good),
    .i_aux_pwr(1'b1), .i_card_present(card_in), .i_card_wake(card_wake), .o_mem_io_en(mem_io),
    .o_master_en(master), .o_irq_en(irq), .o_drivers_en(drv), .o_card_clk_run(cclk),
    .o_card_bus_reset_n(card_bus_reset_n_n), .o_slot_vcc_en(slot), .o_wake_req(wake), .o_power_state(pstate));
  bpsc_host #(.D2_REC_CYC(D2R), .D3_REC_CYC(D3R)) u_bpsc_host (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_req(req), .i_wr(wr), .i_addr(addr), .i_wdata(wdata),
    .o_ready(ready), .o_refused(refused), .o_rvalid(rvalid), .o_rdata(rdata), .cfg(link.host));
  bpsc_properties u_bpsc_properties (
    .i_ref_clk(clk), .i_rst_b(rst_b), .cfg_wr(link.cfg_wr), .cfg_rd(link.cfg_rd), .cfg_addr(link.cfg_addr),
    .cfg_wdata(link.cfg_wdata), .cfg_rvalid(link.cfg_rvalid), .i_vcc_good(vcc_good),
    .i_card_present(card_in), .o_mem_io_en(mem_io), .o_master_en(master), .o_irq_en(irq),
    .o_drivers_en(drv), .o_card_clk_run(cclk), .o_card_bus_reset_n(card_bus_reset_n_n), .o_slot_vcc_en(slot),
    .o_power_state(pstate));
  // ----------------
  // shared tasks
  // ----------------
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_ready();
    wn = 0;
    while (ready !== 1'b1 && wn < 400) begin
      tick(1);
      wn++;
    end
    if (wn == 400) begin
      chk("ready", 16'h0, 16'h1);
      results();
    end
  endtask : wait_ready
  // unknown read data until answered, so a lost answer shows as a mismatch
  task automatic op(input logic w, input logic [1:0] a, input logic [15:0] d);
    rd = 'x;
    rf = 1'b0;
    wait_ready();
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    repeat (5) begin
      #1;
      rf = rf | (refused === 1'b1);
      if (rvalid === 1'b1) begin
        rd = rdata;
      end
      @(posedge clk);
    end
    #1;
  endtask : op
  task automatic bus_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    tick(3);
    @(posedge clk);
    rst_b <= 1'b1;
    tick(3);
  endtask : bus_reset
  // ----------------
  // scenarios
  // ----------------
  task automatic s_defaults();
    op(1'b0, `BPSC_REG_CAPS, 16'h0);
    chk("caps", rd, `BPSC_CAPS_RST);
    op(1'b0, `BPSC_REG_POWER_CONTROL_STATUS_REG, 16'h0);
    chk("power_control_status_reg", rd, 16'h0000);
    chk("uninit", 16'({mem_io, master, irq}), 16'h0);
    op(1'b1, `BPSC_REG_CMD, 16'h001f);
    chk("active", 16'({mem_io, master, irq}), 16'h7);
  endtask : s_defaults
  task automatic s_d2();
    op(1'b1, `BPSC_REG_POWER_CONTROL_STATUS_REG, 16'h0001);
    chk("d1 state", 16'({pstate, cclk, mem_io}), 16'h6);
    op(1'b1, `BPSC_REG_POWER_CONTROL_STATUS_REG, 16'h0002);
    chk("d2 field", 16'(pstate), 16'h2);
    chk("d2 gating", 16'({mem_io, master, irq, cclk}), 16'h0);
    op(1'b0, `BPSC_REG_POWER_CONTROL_STATUS_REG, 16'h0);
    chk("d2 read", rd & 16'h0003, 16'h0002);
    op(1'b1, `BPSC_REG_POWER_CONTROL_STATUS_REG, 16'h0000);
    wait_ready();
    chk("d2 hold", 16'(wn >= D2R - 6), 16'h1);
    chk("d2 exit", 16'(pstate), 16'h0);
  endtask : s_d2
  task automatic s_d3hot();
    op(1'b1, `BPSC_REG_POWER_CONTROL_STATUS_REG, 16'h0103);
    op(1'b0, `BPSC_REG_POWER_CONTROL_STATUS_REG, 16'h0);
    chk("d3 read", rd & 16'h0103, 16'h0103);
    op(1'b1, `BPSC_REG_POWER_CONTROL_STATUS_REG, 16'h0101);
    chk("d3 refuse", 16'({rf, pstate}), 16'h7);
    op(1'b1, `BPSC_REG_POWER_CONTROL_STATUS_REG, 16'h0100);
    chk("soft pins", 16'({drv, card_bus_reset_n_n}), 16'h1);
    wait_ready();
    chk("d3 hold", 16'(wn >= D3R - 6), 16'h1);
    op(1'b0, `BPSC_REG_POWER_CONTROL_STATUS_REG, 16'h0);
    chk("soft ctx", rd & 16'h0103, 16'h0100);
    chk("soft uninit", 16'(master), 16'h0);
  endtask : s_d3hot
  task automatic s_wake();
    op(1'b1, `BPSC_REG_SOCK, 16'h0001);
    @(posedge clk);
    card_wake <= 1'b1;
    tick(4);
    @(posedge clk);
    card_wake <= 1'b0;
    tick(4);
    chk("wake req", 16'(wake), 16'h1);
    bus_reset();
    op(1'b0, `BPSC_REG_POWER_CONTROL_STATUS_REG, 16'h0);
    chk("ctx reset", rd & 16'h8103, 16'h8100);
    op(1'b0, `BPSC_REG_SOCK, 16'h0);
    chk("sock reset", rd & 16'h01ff, 16'h0101);
    op(1'b1, `BPSC_REG_SOCK, 16'h0101);
    op(1'b0, `BPSC_REG_SOCK, 16'h0);
    chk("evt clear", rd & 16'h01ff, 16'h0001);
  endtask : s_wake
  task automatic s_cold();
    op(1'b1, `BPSC_REG_CMD, 16'h0011);
    chk("slot on", 16'(slot), 16'h1);
    @(posedge clk);
    vcc_good <= 1'b0;
    tick(6);
    chk("cold entry", 16'({pstate, cclk, card_bus_reset_n_n}), 16'hc);
    @(posedge clk);
    card_in <= 1'b0;
    tick(6);
    chk("slot cut", 16'(slot), 16'h0);
    @(posedge clk);
    card_in <= 1'b1;
    vcc_good <= 1'b1;
    tick(6);
    chk("cold held", 16'(pstate), 16'h3);
    chk("slot kept off", 16'(slot), 16'h0);
    bus_reset();
    chk("cold exit", 16'(pstate), 16'h0);
    op(1'b0, `BPSC_REG_CMD, 16'h0);
    chk("cmd default", rd & 16'h001f, 16'h0000);
    op(1'b0, `BPSC_REG_SOCK, 16'h0);
    chk("aux mask", rd & 16'h00ff, 16'h0001);
  endtask : s_cold
  initial begin
    // aux supply first, so supply good is synced before bus reset lets go
    @(posedge clk);
    aux_rst_b <= 1'b1;
    tick(1);
    @(posedge clk);
    rst_b <= 1'b1;
    tick(3);
    s_defaults();
    s_d2();
    s_d3hot();
    s_wake();
    s_cold();
    results();
  end
endmodule : bpsc_tb
